// >>> logic/sync_align_pkg.sv
// Shared constants, types and phase table decoding for latency alignment.
`default_nettype none

package sync_align_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int REG_W = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h05;
    localparam logic [7:0] ADDR_PHASE = 8'h06;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_MASK = 8'h07;
    localparam logic [7:0] CTRL_MANUAL = 8'h04;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    localparam int CTRL_EN_BIT = 2;
    localparam int CTRL_PS_LSB = 0;
    localparam int PS_W = 2;

    // ****************************************************************
    // Timing figures
    // ****************************************************************
    // Skew limit of 0.4 sample clock cycles, held in tenths of a cycle.
    localparam int unsigned LATE_TENTHS = 4;
    localparam int LAT_CYCLES = 4;

    typedef struct packed {
        logic known;
        logic [1:0] dflt;
        logic adj_ok;
        logic [1:0] adj;
        logic [3:0] tenths;
    } phase_info_t;

    // Dual-port selects step 10, 00, 01, 11 from one bin group to the next.
    function automatic logic [1:0] dual_ps(input logic [4:0] grp);
        case (grp)
            5'h00: dual_ps = 2'h2;
            5'h01: dual_ps = 2'h0;
            5'h02: dual_ps = 2'h1;
            default: dual_ps = 2'h3;
        endcase
    endfunction : dual_ps

    // Maps a comparator code to its bin, default and adjusted select.
    function automatic phase_info_t phase_lookup(input logic [7:0] code,
                                                 input logic dual);
        logic [4:0] k;
        logic hit;
        phase_info_t r;
        hit = 1'b1;
        k = 5'h00;
        r = '0;
        case (code)
            8'h03: k = 5'h00;
            8'h04: k = 5'h01;
            8'h05: k = 5'h02;
            8'h15: k = 5'h03;
            8'h25: k = 5'h04;
            8'h35: k = 5'h05;
            8'h45: k = 5'h06;
            8'h55: k = 5'h07;
            8'h54: k = 5'h08;
            8'h53: k = 5'h09;
            8'h52: k = 5'h0a;
            8'h51: k = 5'h0b;
            8'h50: k = 5'h0c;
            8'h40: k = 5'h0d;
            8'h30: k = 5'h0e;
            8'h20: k = 5'h0f;
            8'h10: k = 5'h10;
            8'h00: k = 5'h11;
            8'h01: k = 5'h12;
            8'h02: k = 5'h13;
            default: hit = 1'b0;
        endcase
        r.known = hit;
        if (dual)
        begin
            r.dflt = dual_ps(k / 5'h05);
            r.adj_ok = hit && ((k % 5'h05) >= 5'h03);
            r.adj = dual_ps(5'((k / 5'h05 + 5'h01) % 5'h04));
            r.tenths = 4'((k % 5'h05) * 5'h02);
        end
        else
        begin
            r.dflt = (k >= 5'h05 && k <= 5'h0e) ? 2'h2 : 2'h0;
            r.adj_ok = hit && ((k >= 5'h01 && k <= 5'h04) ||
                               (k >= 5'h0b && k <= 5'h0e));
            r.adj = (k <= 5'h04) ? 2'h2 : 2'h0;
            r.tenths = 4'((k + 5'h05) % 5'h0a);
        end
        return r;
    endfunction : phase_lookup

endpackage : sync_align_pkg

`default_nettype wire

// >>> logic/sync_link_if.sv
// Register link between the alignment controller and one converter.
`timescale 1ns/10ps
`default_nettype none

interface sync_link_if;
    logic req_tgl;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic ack_tgl;
    logic [7:0] rdata;

    modport ctl (
        output req_tgl,
        output wr,
        output addr,
        output wdata,
        input ack_tgl,
        input rdata
    );

    modport dev (
        input req_tgl,
        input wr,
        input addr,
        input wdata,
        output ack_tgl,
        output rdata
    );
endinterface : sync_link_if

`default_nettype wire

// >>> logic/bit_sync.sv
// Two flip-flop synchroniser for a single level.
`timescale 1ns/10ps
`default_nettype none

module bit_sync (
    input wire logic clk,
    input wire logic nrst,
    input wire logic d,
    output logic q
);
    logic meta_q;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : bit_sync

`default_nettype wire

// >>> logic/conv_sync_dev.sv
// Converter end: synchroniser registers, phase select and sample latency.
`timescale 1ns/10ps
`default_nettype none

module conv_sync_dev #(
    parameter int DATA_W = 16,
    parameter int LAT = sync_align_pkg::LAT_CYCLES
) (
    input wire logic lnk_clk,
    input wire logic nrst,
    sync_link_if.dev link,
    input wire logic dual_port,
    input wire logic [7:0] phase_compare_code,
    input wire logic [DATA_W-1:0] sample_in,
    output logic [DATA_W-1:0] sample_out,
    output logic [1:0] latency_phase_select,
    output logic manual_sync_enable,
    output logic latency_reduced
);
    if (LAT < 2 || DATA_W < 1) begin : g_bad
        $error("conv_sync_dev: LAT must be at least 2");
    end

    // ****************************************************************
    // Register link
    // ****************************************************************
    logic req_s;
    logic seen_q;
    logic ack_q;
    logic [7:0] rdata_q;
    logic [7:0] ctrl_q;
    logic [7:0] code_q;

    bit_sync u_req (
        .clk(lnk_clk),
        .nrst(nrst),
        .d(link.req_tgl),
        .q(req_s)
    );

    // Address and data are held by the controller until the answer,
    // so they are stable once the toggle has passed the synchroniser.
    always_ff @(posedge lnk_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            seen_q <= 1'b0;
            ack_q <= 1'b0;
            rdata_q <= sync_align_pkg::READ_UNMAPPED;
            ctrl_q <= sync_align_pkg::CTRL_RESET;
        end
        else if (req_s != seen_q)
        begin
            seen_q <= req_s;
            ack_q <= req_s;
            if (link.wr && link.addr == sync_align_pkg::ADDR_CTRL)
            begin
                ctrl_q <= link.wdata & sync_align_pkg::CTRL_MASK;
            end
            if (link.addr == sync_align_pkg::ADDR_CTRL)
            begin
                rdata_q <= ctrl_q;
            end
            else if (link.addr == sync_align_pkg::ADDR_PHASE)
            begin
                rdata_q <= code_q;
            end
            else
            begin
                rdata_q <= sync_align_pkg::READ_UNMAPPED;
            end
        end
    end

    assign link.ack_tgl = ack_q;
    assign link.rdata = rdata_q;

    // ****************************************************************
    // Phase select
    // ****************************************************************
    always_ff @(posedge lnk_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            code_q <= 8'h00;
        end
        else
        begin
            code_q <= phase_compare_code;
        end
    end

    sync_align_pkg::phase_info_t info;
    logic man;
    logic [1:0] ps;
    logic reduce;

    assign info = sync_align_pkg::phase_lookup(code_q, dual_port);
    assign man = ctrl_q[sync_align_pkg::CTRL_EN_BIT];
    // Automatic choice follows the bin table unless software took over.
    assign ps = man
              ? ctrl_q[sync_align_pkg::CTRL_PS_LSB +: sync_align_pkg::PS_W]
              : info.dflt;
    assign reduce = man && info.adj_ok && (ps == info.adj);

    // ****************************************************************
    // Sample path
    // ****************************************************************
    logic [DATA_W-1:0] pipe_q [LAT];
    logic [DATA_W-1:0] out_q;
    logic [1:0] ps_q;
    logic man_q;
    logic red_q;

    always_ff @(posedge lnk_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < LAT; i++)
            begin
                pipe_q[i] <= '0;
            end
            out_q <= '0;
        end
        else
        begin
            pipe_q[0] <= sample_in;
            for (int i = 1; i < LAT; i++)
            begin
                pipe_q[i] <= pipe_q[i-1];
            end
            // One tap earlier removes exactly one sample cycle.
            out_q <= reduce ? pipe_q[LAT-2] : pipe_q[LAT-1];
        end
    end

    always_ff @(posedge lnk_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ps_q <= 2'h0;
            man_q <= 1'b0;
            red_q <= 1'b0;
        end
        else
        begin
            ps_q <= ps;
            man_q <= man;
            red_q <= reduce;
        end
    end

    assign sample_out = out_q;
    assign latency_phase_select = ps_q;
    assign manual_sync_enable = man_q;
    assign latency_reduced = red_q;
endmodule : conv_sync_dev

`default_nettype wire

// >>> logic/sync_align_ctl.sv
// Controller end: reads the phase code and removes a cycle when late.
`timescale 1ns/10ps
`default_nettype none

module sync_align_ctl #(
    parameter int unsigned MON_PERIOD = 1000
) (
    input wire logic clk_sys,
    input wire logic nrst,
    sync_link_if.ctl link,
    input wire logic dual_port,
    input wire logic start,
    input wire logic align,
    input wire logic [3:0] min_delay_tenths,
    input wire logic monitor_en,
    output logic busy,
    output logic code_valid,
    output logic [7:0] phase_code,
    output logic [3:0] delay_tenths,
    output logic code_known,
    output logic late,
    output logic manual_on,
    output logic done
);
    localparam int CNT_W = 16;
    if (MON_PERIOD < 1 || MON_PERIOD >= 2 ** CNT_W) begin : g_bad
        $error("sync_align_ctl: MON_PERIOD out of range");
    end
    localparam logic [CNT_W-1:0] MON_RELOAD = CNT_W'(MON_PERIOD - 1);

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_READ = 2'h1,
        ST_HAVE = 2'h3,
        ST_WRITE = 2'h2
    } state_t;

    // ****************************************************************
    // Link answer
    // ****************************************************************
    logic ack_s;
    logic req_q;
    logic wr_q;
    logic [7:0] addr_q;
    logic [7:0] wdata_q;
    logic link_idle;
    bit_sync u_ack (
        .clk(clk_sys),
        .nrst(nrst),
        .d(link.ack_tgl),
        .q(ack_s)
    );
    assign link_idle = (ack_s == req_q);

    // ****************************************************************
    // Decision
    // ****************************************************************
    state_t state_q;
    state_t state_d;
    logic [7:0] code_q;
    logic auto_q;
    logic manual_q;
    logic go;
    logic auto_due;
    logic [CNT_W-1:0] mon_q;
    sync_align_pkg::phase_info_t info;
    sync_align_pkg::phase_info_t rd_info;
    logic [4:0] need;
    logic late_now;
    logic do_write;
    logic [7:0] wr_val;
    assign info = sync_align_pkg::phase_lookup(code_q, dual_port);
    assign rd_info = sync_align_pkg::phase_lookup(link.rdata, dual_port);
    assign need = {1'b0, min_delay_tenths}
                + 5'(sync_align_pkg::LATE_TENTHS);
    // Bin lower bounds are compared, which is safe only while the
    // data clock skew stays inside its limit.
    assign late_now = info.adj_ok
                   && ({1'b0, info.tenths} >= need);
    assign go = align || auto_q;
    assign auto_due = monitor_en && manual_q && (mon_q == '0);
    assign do_write = late_now || manual_q;
    // Only the manual enable and select bits are ever set.
    assign wr_val = sync_align_pkg::CTRL_MANUAL
                  | {6'h00, late_now ? info.adj : info.dflt};

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:
            begin
                if (start || auto_due)
                begin
                    state_d = ST_READ;
                end
            end
            ST_READ:
            begin
                if (link_idle)
                begin
                    state_d = ST_HAVE;
                end
            end
            ST_HAVE:
            begin
                if (go)
                begin
                    state_d = do_write ? ST_WRITE : ST_IDLE;
                end
            end
            ST_WRITE:
            begin
                if (link_idle)
                begin
                    state_d = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= ST_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ****************************************************************
    // Link requests
    // ****************************************************************
    // A request stays on the link until its answer, so the far end may
    // sample address and data long after the toggle.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            req_q <= 1'b0;
            wr_q <= 1'b0;
            addr_q <= 8'h00;
            wdata_q <= 8'h00;
        end
        else if (state_q == ST_IDLE && state_d == ST_READ)
        begin
            req_q <= ~req_q;
            wr_q <= 1'b0;
            addr_q <= sync_align_pkg::ADDR_PHASE;
            wdata_q <= 8'h00;
        end
        else if (state_q == ST_HAVE && state_d == ST_WRITE)
        begin
            req_q <= ~req_q;
            wr_q <= 1'b1;
            addr_q <= sync_align_pkg::ADDR_CTRL;
            wdata_q <= wr_val;
        end
    end

    assign link.req_tgl = req_q;
    assign link.wr = wr_q;
    assign link.addr = addr_q;
    assign link.wdata = wdata_q;

    // ****************************************************************
    // Read results
    // ****************************************************************
    logic cv_q;
    logic [3:0] delay_q;
    logic known_q;
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            code_q <= 8'h00;
            delay_q <= 4'h0;
            known_q <= 1'b0;
            cv_q <= 1'b0;
        end
        else
        begin
            cv_q <= 1'b0;
            if (state_q == ST_READ && link_idle)
            begin
                code_q <= link.rdata;
                delay_q <= rd_info.tenths;
                known_q <= rd_info.known;
                cv_q <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Mode and monitoring
    // ****************************************************************
    logic late_q;
    logic done_q;
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            auto_q <= 1'b0;
            manual_q <= 1'b0;
            late_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            if (state_q == ST_IDLE && state_d == ST_READ)
            begin
                auto_q <= auto_due && !start;
            end
            if (state_q == ST_HAVE && go)
            begin
                late_q <= late_now;
                done_q <= !do_write;
            end
            if (state_q == ST_WRITE && link_idle)
            begin
                manual_q <= 1'b1;
                done_q <= 1'b1;
            end
        end
    end

    // Drift check period; the count only runs while idle.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            mon_q <= MON_RELOAD;
        end
        else if (state_q != ST_IDLE)
        begin
            mon_q <= MON_RELOAD;
        end
        else if (monitor_en && manual_q && mon_q != '0)
        begin
            mon_q <= mon_q - CNT_W'(1);
        end
    end

    assign busy = (state_q != ST_IDLE);
    assign code_valid = cv_q;
    assign phase_code = code_q;
    assign delay_tenths = delay_q;
    assign code_known = known_q;
    assign late = late_q;
    assign manual_on = manual_q;
    assign done = done_q;
endmodule : sync_align_ctl

`default_nettype wire

// >>> verif/sync_align_asserts.sv
// Concurrent checks on the alignment link and both of its ends.
`timescale 1ns/10ps
`default_nettype none

module sync_align_asserts (
    input wire logic clk_sys,
    input wire logic lnk_clk,
    input wire logic nrst,
    input wire logic req_tgl,
    input wire logic wr,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic ack_tgl,
    input wire logic start,
    input wire logic busy,
    input wire logic code_valid,
    input wire logic done,
    input wire logic manual_sync_enable,
    input wire logic latency_reduced,
    input wire logic [15:0] sample_in,
    input wire logic [15:0] sample_out
);
    // ****************************************************************
    // Settling counter
    // ****************************************************************
    // The output tap moves on the same edge as the flag, yet the delay
    // is judged only once the flag has been steady for eight edges.
    logic reduced_q;
    logic [3:0] settle_q;

    always_ff @(posedge lnk_clk or negedge nrst)
    begin
        if (!nrst)
            reduced_q <= 1'b0;
        else
            reduced_q <= latency_reduced;
    end

    always_ff @(posedge lnk_clk or negedge nrst)
    begin
        if (!nrst)
            settle_q <= 4'h0;
        else if (reduced_q != latency_reduced)
            settle_q <= 4'h0;
        else if (settle_q != 4'h8)
            settle_q <= settle_q + 4'h1;
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    req_hold_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        (req_tgl != ack_tgl) |=> $stable({req_tgl, wr, addr, wdata}))
        else $error("request changed before its answer");
    ack_answer_a: assert property (@(posedge lnk_clk)
        disable iff (!nrst)
        $changed(req_tgl) |-> ##[1:4] (ack_tgl == req_tgl))
        else $error("request not answered in time");
    ack_match_a: assert property (@(posedge lnk_clk)
        disable iff (!nrst)
        $changed(ack_tgl) |-> (ack_tgl == req_tgl))
        else $error("answer without a request");
    valid_pulse_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        code_valid |-> busy ##1 !code_valid)
        else $error("code valid is not a single pulse");
    done_idle_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        done |-> !busy ##1 !done)
        else $error("done while busy or held");
    start_busy_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        (start && !busy) |=> busy)
        else $error("start not taken in idle");
    manual_gate_a: assert property (@(posedge lnk_clk)
        disable iff (!nrst)
        !manual_sync_enable |-> !latency_reduced)
        else $error("latency reduced outside manual mode");
    write_value_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        ($changed(req_tgl) && wr) |-> ((wdata & 8'hfc) == 8'h04))
        else $error("control write sets more than enable and select");
    lat_full_a: assert property (@(posedge lnk_clk)
        disable iff (!nrst)
        (settle_q == 4'h8 && !latency_reduced)
        |-> sample_out == $past(sample_in, 5))
        else $error("default latency wrong");
    lat_short_a: assert property (@(posedge lnk_clk)
        disable iff (!nrst)
        (settle_q == 4'h8 && latency_reduced)
        |-> sample_out == $past(sample_in, 4))
        else $error("reduced latency wrong");

    done_c: cover property (@(posedge clk_sys) disable iff (!nrst) done);
    valid_c: cover property (@(posedge clk_sys) disable iff (!nrst) code_valid);
    short_c: cover property (@(posedge lnk_clk) disable iff (!nrst)
        settle_q == 4'h8 && latency_reduced);
endmodule : sync_align_asserts

`default_nettype wire

// >>> verif/tb.sv
// Testbench joining the controller end and the converter end.
`timescale 1ns/10ps
`default_nettype none

module tb;
    // ****************************************************************
    // Signals and ends
    // ****************************************************************
    logic clk_sys = 1'b0;
    logic lnk_clk = 1'b0;
    logic nrst = 1'b0;
    logic dual_port = 1'b1;
    logic start = 1'b0;
    logic align = 1'b0;
    logic monitor_en = 1'b0;
    logic [3:0] min_delay_tenths = 4'h0;
    logic [7:0] phase_compare_code = 8'h03;
    logic [15:0] sample_in = 16'h0000;
    logic [15:0] sample_out;
    logic [1:0] latency_phase_select;
    logic manual_sync_enable;
    logic latency_reduced;
    logic busy;
    logic code_valid;
    logic [7:0] phase_code;
    logic [3:0] delay_tenths;
    logic code_known;
    logic late;
    logic manual_on;
    logic done;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    // Rows: dual, code, default select; the last code is outside the table.
    localparam logic [10:0] DFLT [8] = '{{1'b1, 8'h03, 2'h2},
        {1'b1, 8'h35, 2'h0}, {1'b1, 8'h52, 2'h1}, {1'b1, 8'h20, 2'h3},
        {1'b0, 8'h35, 2'h2}, {1'b0, 8'h03, 2'h0}, {1'b0, 8'h20, 2'h0},
        {1'b0, 8'h7f, 2'h0}};
    // Rows: dual, code, minimum, late, select, tenths.
    localparam logic [19:0] ADJ [11] = '{{1'b1, 8'h25, 4'h0, 1'b1, 2'h0, 4'h8},
        {1'b1, 8'h54, 4'h0, 1'b1, 2'h1, 4'h6},
        {1'b1, 8'h30, 4'h0, 1'b1, 2'h3, 4'h8},
        {1'b1, 8'h01, 4'h0, 1'b1, 2'h2, 4'h6},
        {1'b1, 8'h15, 4'h4, 1'b0, 2'h2, 4'h6},
        {1'b1, 8'h05, 4'h0, 1'b0, 2'h2, 4'h4},
        {1'b1, 8'h53, 4'h4, 1'b1, 2'h1, 4'h8},
        {1'b0, 8'h04, 4'h0, 1'b1, 2'h2, 4'h6},
        {1'b0, 8'h51, 4'h0, 1'b1, 2'h0, 4'h6},
        {1'b0, 8'h30, 4'h2, 1'b1, 2'h0, 4'h9},
        {1'b0, 8'h53, 4'h0, 1'b0, 2'h2, 4'h4}};

    sync_link_if link();

    sync_align_ctl #(.MON_PERIOD(8)) i_sync_align_ctl (.clk_sys(clk_sys),
        .nrst(nrst), .link(link), .dual_port(dual_port), .start(start),
        .align(align), .min_delay_tenths(min_delay_tenths),
        .monitor_en(monitor_en), .busy(busy), .code_valid(code_valid),
        .phase_code(phase_code), .delay_tenths(delay_tenths),
        .code_known(code_known), .late(late), .manual_on(manual_on),
        .done(done));
    conv_sync_dev i_conv_sync_dev (.lnk_clk(lnk_clk), .nrst(nrst),
        .link(link), .dual_port(dual_port),
        .phase_compare_code(phase_compare_code), .sample_in(sample_in),
        .sample_out(sample_out), .latency_phase_select(latency_phase_select),
        .manual_sync_enable(manual_sync_enable),
        .latency_reduced(latency_reduced));
    sync_align_asserts i_sync_align_asserts (.clk_sys(clk_sys),
        .lnk_clk(lnk_clk), .nrst(nrst), .req_tgl(link.req_tgl), .wr(link.wr),
        .addr(link.addr), .wdata(link.wdata), .ack_tgl(link.ack_tgl),
        .start(start), .busy(busy), .code_valid(code_valid), .done(done),
        .manual_sync_enable(manual_sync_enable),
        .latency_reduced(latency_reduced), .sample_in(sample_in),
        .sample_out(sample_out));

    always #20 clk_sys = ~clk_sys;
    always #24 lnk_clk = ~lnk_clk;
    always @(posedge lnk_clk) sample_in <= #1 sample_in + 16'h0001;

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic conclude();
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude

    // Reset is long enough for three link edges as the device needs.
    task automatic do_reset(input logic dual, input logic [7:0] code);
        @(posedge clk_sys);
        #1;
        nrst = 1'b0;
        monitor_en = 1'b0;
        dual_port = dual;
        phase_compare_code = code;
        repeat (20) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
    endtask : do_reset

    task automatic run_align(input logic [3:0] min);
        int n;
        min_delay_tenths = min;
        start = 1'b1;
        @(posedge clk_sys);
        #1;
        start = 1'b0;
        for (n = 0; n < 100 && code_valid !== 1'b1; n++) @(posedge clk_sys) #1;
        check({7'h0, code_valid}, 8'h01);
        align = 1'b1;
        @(posedge clk_sys);
        #1;
        align = 1'b0;
        for (n = 0; n < 100 && done !== 1'b1; n++) @(posedge clk_sys) #1;
        check({7'h0, done}, 8'h01);
        repeat (12) @(posedge lnk_clk);
        #1;
    endtask : run_align

    task automatic t_defaults();
        foreach (DFLT[i])
        begin
            do_reset(DFLT[i][10], DFLT[i][9:2]);
            check({6'h0, latency_phase_select}, {6'h0, DFLT[i][1:0]});
            check({7'h0, manual_sync_enable}, 8'h00);
        end
        $display("t_defaults done");
    endtask : t_defaults

    task automatic t_adjust();
        logic [19:0] r;
        foreach (ADJ[i])
        begin
            r = ADJ[i];
            do_reset(r[19], r[18:11]);
            run_align(r[10:7]);
            check(phase_code, r[18:11]);
            check({7'h0, code_known}, 8'h01);
            check({7'h0, manual_on}, {7'h0, r[6]});
            check({4'h0, delay_tenths}, {4'h0, r[3:0]});
            check({7'h0, late}, {7'h0, r[6]});
            check({7'h0, manual_sync_enable}, {7'h0, r[6]});
            check({6'h0, latency_phase_select}, {6'h0, r[5:4]});
            check({7'h0, latency_reduced}, {7'h0, r[6]});
        end
        $display("t_adjust done");
    endtask : t_adjust

    task automatic t_monitor();
        int n;
        do_reset(1'b1, 8'h25);
        run_align(4'h0);
        monitor_en = 1'b1;
        @(posedge lnk_clk);
        #1;
        phase_compare_code = 8'h03;
        for (n = 0; n < 400 && latency_phase_select !== 2'h2; n++)
            @(posedge clk_sys) #1;
        repeat (12) @(posedge lnk_clk);
        #1;
        check({6'h0, latency_phase_select}, 8'h02);
        check({7'h0, manual_sync_enable}, 8'h01);
        check({7'h0, latency_reduced}, 8'h00);
        monitor_en = 1'b0;
        $display("t_monitor done");
    endtask : t_monitor

    // ****************************************************************
    // Sequence
    // ****************************************************************
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            miscompares++;
            $display("FAIL at %0t: got %h exp %h", $time, cycles, 0);
            conclude();
        end
    end

    initial
    begin
        t_defaults();
        t_adjust();
        t_monitor();
        conclude();
    end
endmodule : tb

`default_nettype wire
